// ---- hdl/tssm_regs.vh ----
`ifndef TSSM_REGS_VH
`define TSSM_REGS_VH
// Register byte offsets
`define TSSM_OFF_CTRL      12'h000
`define TSSM_OFF_STATUS    12'h004
`define TSSM_OFF_RX_TBL    12'h400
`define TSSM_OFF_TX_TBL    12'h800
`define TSSM_TBL_MASK      12'hC00
// Entry field positions
`define TSSM_F_VALID       15
`define TSSM_F_WRAP        14
`define TSSM_F_MSK_HI      13
`define TSSM_F_MSK_HI_LO   12
`define TSSM_F_LAST        11
`define TSSM_F_PTR_HI      10
`define TSSM_F_PTR_LO      6
`define TSSM_F_MSK_LO      5
// Control bits
`define TSSM_C_RX_EN       0
`define TSSM_C_TX_EN       1
// Reset values
`define TSSM_CTRL_RST      2'h0
`define TSSM_ENTRY_RST     16'h0000
// Base address low zero bits
`define TSSM_BASE_ZERO     6
`define TSSM_SLOT_BITS     8
`endif

// ---- hdl/tssm_sync.v ----
module tssm_sync (
  input  wire clk_in,
  input  wire rst_b_in,
  input  wire ce_in,
  input  wire d_in,
  output reg  q_out,
  output wire rise_out,
  output wire fall_out
);
  // Stage one feeds stage two only; change counted when stages two and three agree
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      q_out <= 1'b0;
    end else if (ce_in) begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_out <= s3_r;
      end
    end
  end
  assign rise_out = ce_in & (s2_r == s3_r) & s3_r & ~q_out;
  assign fall_out = ce_in & (s2_r == s3_r) & ~s3_r & q_out;
endmodule // tssm_sync

// ---- hdl/tssm_apb.v ----
`include "tssm_regs.vh"
module tssm_apb (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire        ce_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [31:0] rdata_in,
  input  wire        map_ok_in,
  output wire        pready_out,
  output wire        pslverr_out,
  output reg  [31:0] prdata_out,
  output wire        wr_out
);
  // No wait state: read data registered in setup, answer in first access cycle
  assign pready_out  = psel_in & penable_in;
  assign pslverr_out = psel_in & penable_in & ~map_ok_in;
  assign wr_out      = ce_in & psel_in & penable_in & pwrite_in & map_ok_in;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h00000000;
    end else if (ce_in && psel_in && !penable_in) begin
      prdata_out <= map_ok_in ? rdata_in : 32'h00000000;
    end
  end
endmodule // tssm_apb

// ---- hdl/tssm_top.v ----
// Behaviour
// - One 8-bit slot splits into bit subchannels, one table entry each.
// - Entry bit 11 is the last-subchannel flag, not pointer.
// - Channel pointer is 5 bits, 32 rx and 32 tx channels.
// - Parameter base is pointer followed by six zero bits, 11 bits.
// - Invalid rx entry discards slot data, nothing written.
// - Valid rx entry writes selected bits to pointed channel.
// - After wrap entry, restart at entry 0 on frame sync.
// - Last flag moves to next slot; clear reuses slot for next entry.
// - Rx processes only mask-1 bits; mask-0 advances no counter.
// - Invalid tx entry drives logic 1 for whole slot.
// - Valid tx entry sends pointed channel data in masked bits.
// - Tx mask-1 bits carry channel data; mask-0 bits driven high.
// - Any 32 channels map to any slots and subchannels.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`include "tssm_regs.vh"
module tssm_top #(
  parameter ENTRIES = 64,
  parameter AW      = 6
) (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire        ce_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output wire        pslverr_out,
  output wire [31:0] prdata_out,
  input  wire        link_clk_in,
  input  wire        fsync_in,
  input  wire        rxd_in,
  output reg         txd_out,
  output reg         rx_bit_valid_out,
  output reg         rx_bit_out,
  output reg  [4:0]  rx_chan_out,
  output reg  [10:0] rx_base_out,
  output reg         tx_bit_req_out,
  output reg  [4:0]  tx_chan_out,
  output reg  [10:0] tx_base_out,
  input  wire        tx_bit_in
);
  reg  [15:0]   rx_tbl [0:ENTRIES-1];
  reg  [15:0]   tx_tbl [0:ENTRIES-1];
  reg  [1:0]    ctrl_r;
  reg  [AW-1:0] rx_idx_r;
  reg  [AW-1:0] tx_idx_r;
  reg  [AW-1:0] rx_first_r;
  reg  [AW-1:0] tx_first_r;
  reg  [2:0]    rx_pos_r;
  reg  [2:0]    tx_pos_r;
  reg  [7:0]    rx_slot_r;
  reg  [15:0]   tx_slot_r;
  reg           tx_load_r;
  reg           rx_run_r;
  reg           tx_run_r;
  wire          lclk;
  wire          lrise;
  wire          lfall;
  wire          fs;
  wire          rxd;
  wire          wr;
  reg  [31:0]   rdata;
  reg           map_ok;
  wire [AW-1:0] tidx;
  wire [15:0]   rx_e;
  wire [15:0]   tx_e;
  integer       i;

  // Mask bit for slot position p (position 0 first on the line)
  function msk_bit;
    input [15:0] e;
    input [2:0]  p;
    reg   [7:0]  m;
    begin
      m = {e[`TSSM_F_MSK_HI:`TSSM_F_MSK_HI_LO], e[`TSSM_F_MSK_LO:0]};
      msk_bit = m[3'h7 - p];
    end
  endfunction

  // Parameter base from pointer with low bits zero
  function [10:0] base_of;
    input [15:0] e;
    begin
      base_of = {e[`TSSM_F_PTR_HI:`TSSM_F_PTR_LO], 6'h00};
    end
  endfunction

  tssm_sync u_clk (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .d_in(link_clk_in), .q_out(lclk), .rise_out(lrise), .fall_out(lfall));
  tssm_sync u_fs (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .d_in(fsync_in), .q_out(fs), .rise_out(), .fall_out());
  tssm_sync u_rxd (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .d_in(rxd_in), .q_out(rxd), .rise_out(), .fall_out());

  assign tidx = paddr_in[AW+1:2];
  assign rx_e = rx_tbl[rx_idx_r];
  assign tx_e = tx_tbl[tx_idx_r];

  always @* begin
    rdata  = 32'h00000000;
    map_ok = 1'b1;
    if (paddr_in == `TSSM_OFF_CTRL) begin
      rdata = {30'h00000000, ctrl_r};
    end else if (paddr_in == `TSSM_OFF_STATUS) begin
      rdata = {16'h0000, 2'h0, tx_idx_r, 2'h0, rx_idx_r};
    end else if (((paddr_in & `TSSM_TBL_MASK) == `TSSM_OFF_RX_TBL) &&
                 (paddr_in[9:AW+2] == 0) && (paddr_in[1:0] == 2'h0)) begin
      rdata = {16'h0000, rx_tbl[tidx]};
    end else if (((paddr_in & `TSSM_TBL_MASK) == `TSSM_OFF_TX_TBL) &&
                 (paddr_in[9:AW+2] == 0) && (paddr_in[1:0] == 2'h0)) begin
      rdata = {16'h0000, tx_tbl[tidx]};
    end else begin
      map_ok = 1'b0;
    end
  end

  tssm_apb u_apb (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .rdata_in(rdata),
    .map_ok_in(map_ok), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .prdata_out(prdata_out), .wr_out(wr));

  // Tables are plain storage, no reset, so software must fill them before enabling
  always @(posedge clk_in) begin
    if (wr && (paddr_in & `TSSM_TBL_MASK) == `TSSM_OFF_RX_TBL) begin
      rx_tbl[tidx] <= pwdata_in[15:0];
    end
    if (wr && (paddr_in & `TSSM_TBL_MASK) == `TSSM_OFF_TX_TBL) begin
      tx_tbl[tidx] <= pwdata_in[15:0];
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_r <= `TSSM_CTRL_RST;
    end else if (wr && paddr_in == `TSSM_OFF_CTRL) begin
      ctrl_r <= pwdata_in[1:0];
    end
  end

  // Receive: sample on link rising edge; a slot's 8 bits are buffered then
  // replayed against each subchannel entry of that slot
  reg [2:0] rx_cnt_r;
  reg [7:0] rx_hold_r;
  reg       rx_full_r;
  reg [3:0] rx_scan_r;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_idx_r         <= {AW{1'b0}};
      rx_first_r       <= {AW{1'b0}};
      rx_cnt_r         <= 3'h0;
      rx_slot_r        <= 8'h00;
      rx_hold_r        <= 8'h00;
      rx_full_r        <= 1'b0;
      rx_scan_r        <= 4'h0;
      rx_pos_r         <= 3'h0;
      rx_run_r         <= 1'b0;
      rx_bit_valid_out <= 1'b0;
      rx_bit_out       <= 1'b0;
      rx_chan_out      <= 5'h00;
      rx_base_out      <= 11'h000;
    end else if (ce_in) begin
      rx_bit_valid_out <= 1'b0;
      if (!ctrl_r[`TSSM_C_RX_EN]) begin
        rx_run_r  <= 1'b0;
        rx_full_r <= 1'b0;
        rx_idx_r  <= {AW{1'b0}};
      end else begin
        // Replay reads a held copy, so the next slot keeps arriving meanwhile
        if (rx_full_r) begin
          if (rx_scan_r[3] == 1'b0) begin
            rx_pos_r  <= rx_scan_r[2:0];
            rx_scan_r <= rx_scan_r + 4'h1;
            if (rx_e[`TSSM_F_VALID] && msk_bit(rx_e, rx_scan_r[2:0])) begin
              rx_bit_valid_out <= 1'b1;
              rx_bit_out       <= rx_hold_r[3'h7 - rx_scan_r[2:0]];
              rx_chan_out      <= rx_e[`TSSM_F_PTR_HI:`TSSM_F_PTR_LO];
              rx_base_out      <= base_of(rx_e);
            end
          end else begin
            rx_scan_r <= 4'h0;
            if (rx_e[`TSSM_F_WRAP]) begin
              rx_full_r <= 1'b0;
              rx_run_r  <= 1'b0;
            end else if (rx_e[`TSSM_F_LAST]) begin
              rx_full_r  <= 1'b0;
              rx_idx_r   <= rx_idx_r + 1'b1;
              rx_first_r <= rx_idx_r + 1'b1;
            end else begin
              rx_idx_r <= rx_idx_r + 1'b1;
            end
          end
        end
        // Collection comes last so a frame start or a full slot wins
        if (lrise && fs) begin
          rx_run_r   <= 1'b1;
          rx_idx_r   <= {AW{1'b0}};
          rx_first_r <= {AW{1'b0}};
          rx_slot_r  <= {rxd, 7'h00};
          rx_cnt_r   <= 3'h1;
        end else if (lrise && rx_run_r) begin
          rx_slot_r[3'h7 - rx_cnt_r] <= rxd;
          rx_cnt_r <= rx_cnt_r + 3'h1;
          if (rx_cnt_r == 3'h7) begin
            rx_hold_r <= {rx_slot_r[7:1], rxd};
            rx_full_r <= 1'b1;
            rx_scan_r <= 4'h0;
          end
        end
      end
    end
  end

  // Transmit: change on link falling edge; each bit combines all subchannel
  // entries of the slot, ones wherever no valid entry selects the bit
  reg [AW-1:0] tx_scan_idx_r;
  reg          tx_bld_r;
  reg [2:0]    tx_bp_r;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_idx_r       <= {AW{1'b0}};
      tx_first_r     <= {AW{1'b0}};
      tx_pos_r       <= 3'h0;
      tx_run_r       <= 1'b0;
      tx_slot_r      <= 16'h0000;
      tx_load_r      <= 1'b0;
      tx_scan_idx_r  <= {AW{1'b0}};
      tx_bld_r       <= 1'b0;
      tx_bp_r        <= 3'h0;
      txd_out        <= 1'b1;
      tx_bit_req_out <= 1'b0;
      tx_chan_out    <= 5'h00;
      tx_base_out    <= 11'h000;
    end else if (ce_in) begin
      tx_bit_req_out <= 1'b0;
      if (!ctrl_r[`TSSM_C_TX_EN]) begin
        tx_run_r <= 1'b0;
        txd_out  <= 1'b1;
        tx_idx_r <= {AW{1'b0}};
      end else if (lfall) begin
        if (fs || (tx_run_r && tx_pos_r == 3'h7)) begin
          // Coming slot restarts at position 0; its bits are fetched into tx_slot_r on later rises
          tx_pos_r <= 3'h0;
        end else begin
          tx_pos_r <= tx_pos_r + 3'h1;
        end
        if (fs) begin
          tx_run_r <= 1'b1;
        end
        txd_out <= tx_run_r ? tx_slot_r[3'h7 - tx_pos_r] : 1'b1;
      end else if (tx_run_r && lrise) begin
        // Fetch the bit for the current position from its owning entry
        tx_bld_r      <= 1'b1;
        tx_scan_idx_r <= tx_first_r;
        tx_bp_r       <= tx_pos_r;
        tx_slot_r[3'h7 - tx_pos_r] <= 1'b1;
      end else if (tx_bld_r) begin
        if (tx_tbl[tx_scan_idx_r][`TSSM_F_VALID] &&
            msk_bit(tx_tbl[tx_scan_idx_r], tx_bp_r)) begin
          tx_bit_req_out <= 1'b1;
          tx_chan_out    <= tx_tbl[tx_scan_idx_r][`TSSM_F_PTR_HI:`TSSM_F_PTR_LO];
          tx_base_out    <= base_of(tx_tbl[tx_scan_idx_r]);
          tx_load_r      <= 1'b1;
          tx_bld_r       <= 1'b0;
        end else if (tx_tbl[tx_scan_idx_r][`TSSM_F_LAST] ||
                     tx_tbl[tx_scan_idx_r][`TSSM_F_WRAP]) begin
          tx_bld_r <= 1'b0;
        end else begin
          tx_scan_idx_r <= tx_scan_idx_r + 1'b1;
        end
        tx_idx_r <= tx_scan_idx_r;
      end else if (tx_load_r) begin
        // Channel answers in the cycle the request is high; tx_bit_in is sampled at its end
        tx_slot_r[3'h7 - tx_bp_r] <= tx_bit_in;
        tx_load_r <= 1'b0;
      end
      if (lfall && tx_run_r && tx_pos_r == 3'h7) begin
        // Skip past this slot's entries
        if (tx_e[`TSSM_F_WRAP] || fs) begin
          tx_first_r <= {AW{1'b0}};
          if (!fs) begin
            tx_run_r <= 1'b0;
          end
        end else begin
          tx_first_r <= tx_idx_r + 1'b1;
        end
      end else if (lfall && fs) begin
        tx_first_r <= {AW{1'b0}};
      end
    end
  end
endmodule // tssm_top

// ---- tb/tssm_checker.sv ----
module tssm_checker (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire        pready_out,
  input wire        pslverr_out,
  input wire [31:0] prdata_out,
  input wire        link_clk_in,
  input wire        txd_out,
  input wire        rx_bit_valid_out,
  input wire [4:0]  rx_chan_out,
  input wire [10:0] rx_base_out,
  input wire        tx_bit_req_out,
  input wire [4:0]  tx_chan_out,
  input wire [10:0] tx_base_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  pready_follows_a: assert property (pready_out == (psel_in && penable_in))
    else $error("pready not tied to access phase");
  err_in_access_a: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("slave error outside access phase");
  err_read_zero_a: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h00000000)
    else $error("refused read returned data");
  rx_base_map_a: assert property (rx_bit_valid_out |-> rx_base_out == {rx_chan_out, 6'h00})
    else $error("rx base not channel times 64");
  tx_base_map_a: assert property (tx_bit_req_out |-> tx_base_out == {tx_chan_out, 6'h00})
    else $error("tx base not channel times 64");
  tx_one_req_a: assert property (tx_bit_req_out |=> (!tx_bit_req_out) [*8])
    else $error("two tx requests in one bit");
  tx_req_high_a: assert property (tx_bit_req_out |-> link_clk_in)
    else $error("tx request outside link high phase");
  txd_after_fall_a: assert property (!$stable(txd_out) |-> !link_clk_in)
    else $error("tx line moved while link high");
endmodule // tssm_checker

bind tssm_top tssm_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .prdata_out(prdata_out), .link_clk_in(link_clk_in),
  .txd_out(txd_out), .rx_bit_valid_out(rx_bit_valid_out), .rx_chan_out(rx_chan_out),
  .rx_base_out(rx_base_out), .tx_bit_req_out(tx_bit_req_out), .tx_chan_out(tx_chan_out),
  .tx_base_out(tx_base_out));

// ---- tb/tssm_link_model.sv ----
module tssm_link_model (
  input  wire txd_in,
  output reg  link_clk_out,
  output reg  fsync_out,
  output reg  rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clk_out = 1'b0;
    fsync_out = 1'b0;
    rxd_out = 1'b0;
  end
  // Clock stands low between frames; tx line bit i is read just before rise i
  task automatic run_frame(input [15:0] rx_bits, output [15:0] tx_bits);
    integer i;
    for (i = 0; i < 16; i++) begin
      rxd_out = rx_bits[15-i];
      fsync_out = (i == 0);
      #32;
      tx_bits[15-i] = txd_in;
      link_clk_out = 1'b1;
      #32;
      link_clk_out = 1'b0;
    end
    fsync_out = 1'b0;
    rxd_out = ~rxd_out;
    #32;
  endtask
endmodule // tssm_link_model

// ---- tb/tssm_top_tb.sv ----
module tssm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg         clk, rst_b, psel, pen, pwr, txb, e;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, q;
  reg  [15:0] txcap;
  reg  [4:0]  c;
  reg  [16:0] rxq[$];
  wire        pready, pslverr, lclk, fsync, rxd, txd, rxv, rxb, txr;
  wire [31:0] prdata;
  wire [4:0]  rxc, txc;
  wire [10:0] rxbase, txbase;
  integer     miscompares, compares, n, k, txn;

  tssm_top dut (.clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .link_clk_in(lclk),
    .fsync_in(fsync), .rxd_in(rxd), .txd_out(txd), .rx_bit_valid_out(rxv),
    .rx_bit_out(rxb), .rx_chan_out(rxc), .rx_base_out(rxbase), .tx_bit_req_out(txr),
    .tx_chan_out(txc), .tx_base_out(txbase), .tx_bit_in(txb));
  tssm_link_model link (.txd_in(txd), .link_clk_out(lclk), .fsync_out(fsync), .rxd_out(rxd));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Idle cycle after release keeps back-to-back calls off one time step
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares = miscompares + 1;
      end_sim;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  function [15:0] ent(input v, w, l, input [4:0] p, input [7:0] m);
    ent = {v, w, m[7:6], l, p, m[5:0]};
  endfunction

  always @(posedge clk) begin
    if (rxv === 1'b1) rxq.push_back({rxc, rxbase, rxb});
    if (txr === 1'b1) begin
      txn = txn + 1;
      chk(txc, 32'h3);
      chk(txbase, 32'hC0);
    end
  end

  initial begin
    {rst_b, psel, pen, pwr, txb, paddr, pwdata} = 0;
    miscompares = 0;
    compares = 0;
    txn = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(0, 12'h000, 0);
    chk(q, 32'h0);
    apb(0, 12'h00C, 0);
    chk(e, 32'h1);
    chk(q, 32'h0);
    apb(1, 12'h400, ent(1, 0, 0, 5'd1, 8'hC0));
    apb(1, 12'h404, ent(1, 0, 1, 5'd31, 8'h3F));
    apb(1, 12'h408, ent(0, 1, 1, 5'd7, 8'hFF));
    apb(1, 12'h800, ent(1, 0, 1, 5'd3, 8'hF0));
    apb(1, 12'h804, ent(0, 1, 1, 5'd4, 8'h00));
    apb(0, 12'h404, 0);
    chk(q, {16'h0, ent(1, 0, 1, 5'd31, 8'h3F)});
    apb(1, 12'h000, 32'h3);
    for (k = 0; k < 2; k++) begin
      rxq.delete();
      txn = 0;
      link.run_frame(16'hA5FF, txcap);
      repeat (60) @(posedge clk);
      chk(txcap, 32'hC3FF);
      chk(txn, 32'h4);
      chk(rxq.size(), 32'h8);
      for (n = 0; n < 8; n++) begin
        c = (n < 2) ? 5'd1 : 5'd31;
        chk(rxq[n], {c, c, 6'h00, 1'((8'hA5 >> (7 - n)) & 8'h01)});
      end
    end
    end_sim;
  end
endmodule // tssm_top_tb
